// [pad_defines.vh]
// address map constants for the physical address decoder
// Notes on behaviour
// - decode every access across the full 40-bit physical address space
// - static memory region from zero, split into 64MB chip-select windows
// - default map: window 0 and window 2 both select nor0
// - 64MB window at 0x00_0400_0000 goes to secure RAM
// - window at 0x00_0C00_0000 selects nor1; 0x00_1000_0000 is spare and reserved
// - window at 0x00_1400_0000 selects psram
// - window at 0x00_1800_0000 selects media peripherals
// - window at 0x00_1C00_0000 up to 0x00_1FFF_FFFF selects system register peripherals
// - 256MB at 0x00_2000_0000 goes to on-chip peripheral region one
// - 256MB at 0x00_3000_0000 goes to the coherency port
// - 0x00_4000_0000 to 0x00_7FBF_FFFF goes to external AXI when that window is enabled
// - 4MB at 0x00_7FC0_0000 goes to on-chip peripheral region two
// - 2GB at 0x00_8000_0000 goes to DDR2 block one
// - four 2GB aliases of DDR2 block one reach the same offset
// - remap external option routes low 512MB to external AXI
// - default remap: static memory at zero, external AXI window enabled
// - another remap keeps static memory at zero but disables AXI window
// - reset clears remap fields to zero
// - after reset, fetches from zero reach nor0 for boot
// - second remap field picks nor0 or nor1 at zero, only with static memory there
`ifndef PAD_DEFINES_VH
`define PAD_DEFINES_VH

`define PAD_AW          40
`define PAD_DDR_OFS_W   31
`define PAD_TGT_W       4

// target codes
`define PAD_TGT_NONE    4'h0
`define PAD_TGT_SMC     4'h1
`define PAD_TGT_SRAM    4'h2
`define PAD_TGT_PERI1   4'h3
`define PAD_TGT_ACP     4'h4
`define PAD_TGT_EXTAXI  4'h5
`define PAD_TGT_PERI2   4'h6
`define PAD_TGT_DDR     4'h7

// remap field values (bits [1:0])
`define PAD_RMP_SMC_AXI_ON  2'h0
`define PAD_RMP_AXI_LOW     2'h1
`define PAD_RMP_SMC_AXI_OFF 2'h2
// chip select remap (bits [5:4])
`define PAD_CSR_NOR0        2'h0
`define PAD_CSR_NOR1        2'h1

// chip select numbers on the static memory controller
`define PAD_CS_NOR0    3'h0
`define PAD_CS_PSRAM   3'h1
`define PAD_CS_MEDIA   3'h2
`define PAD_CS_SYSREG  3'h3
`define PAD_CS_NOR1    3'h4
`define PAD_CS_SPARE   3'h5

// region boundaries, high address bits
`define PAD_LOW4G_TOP   8'h00
`define PAD_ALIAS_A     8'h08
`define PAD_ALIAS_B     8'h80
`define PAD_SMC_END     40'h00_2000_0000
`define PAD_PERI1_END   40'h00_3000_0000
`define PAD_ACP_END     40'h00_4000_0000
`define PAD_AXI_END     40'h00_7FC0_0000
`define PAD_PERI2_END   40'h00_8000_0000
`define PAD_DDR_END     40'h01_0000_0000

`endif

// [pad_smc_window.v]
// static memory window to chip select and secure RAM decode
`timescale 1ns/1ps
`include "pad_defines.vh"
module pad_smc_window (
	input  wire [28:0] addr,
	input  wire [1:0]  cs_remap,
	output reg  [5:0]  cs_onehot,
	output reg         secure_ram,
	output reg         reserved
);
	// ****************************************
	// 64MB window select
	// ****************************************
	reg [2:0] win;
	always @* begin
		win        = addr[28:26];
		cs_onehot  = 6'h00;
		secure_ram = 1'b0;
		reserved   = 1'b0;
		case (win)
			3'h0: begin
				// boot window follows the chip-select remap
				if (cs_remap == `PAD_CSR_NOR1)
					cs_onehot[`PAD_CS_NOR1] = 1'b1;
				else
					cs_onehot[`PAD_CS_NOR0] = 1'b1;
			end
			3'h1: secure_ram = 1'b1;
			3'h2: cs_onehot[`PAD_CS_NOR0] = 1'b1;
			3'h3: cs_onehot[`PAD_CS_NOR1] = 1'b1;
			3'h4: reserved = 1'b1;
			3'h5: cs_onehot[`PAD_CS_PSRAM] = 1'b1;
			3'h6: cs_onehot[`PAD_CS_MEDIA] = 1'b1;
			3'h7: cs_onehot[`PAD_CS_SYSREG] = 1'b1;
			default: reserved = 1'b1;
		endcase
	end
endmodule

// [pad_remap_cfg.v]
// remap configuration holding register
`timescale 1ns/1ps
`include "pad_defines.vh"
module pad_remap_cfg (
	input  wire       clk,
	input  wire       nrst,
	input  wire       cfg_we,
	input  wire [1:0] cfg_remap,
	input  wire [1:0] cfg_cs_remap,
	output reg  [1:0] remap_reg,
	output reg  [1:0] cs_remap_reg
);
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			remap_reg    <= `PAD_RMP_SMC_AXI_ON;
			cs_remap_reg <= `PAD_CSR_NOR0;
		end else if (cfg_we) begin
			remap_reg    <= cfg_remap;
			cs_remap_reg <= cfg_cs_remap;
		end
	end
endmodule

// [pad_addr_decoder.v]
// physical address decoder with remap for the processor bus
`timescale 1ns/1ps
`include "pad_defines.vh"
module pad_addr_decoder (
	input  wire                      clk,
	input  wire                      nrst,
	input  wire                      req_valid,
	input  wire [`PAD_AW-1:0]        req_addr,
	input  wire                      cfg_we,
	input  wire [1:0]                cfg_remap,
	input  wire [1:0]                cfg_cs_remap,
	output wire [1:0]                remap_state,
	output wire [1:0]                cs_remap_state,
	output reg                       dec_valid,
	output reg  [`PAD_TGT_W-1:0]     dec_target,
	output reg  [5:0]                smc_cs,
	output reg  [`PAD_AW-1:0]        dec_addr,
	output reg  [`PAD_DDR_OFS_W-1:0] ddr_offset,
	output reg                       dec_error
);
	// ****************************************
	// configuration
	// ****************************************
	wire [1:0] remap_reg;
	wire [1:0] cs_remap_reg;

	pad_remap_cfg u_cfg (
		.clk          (clk),
		.nrst         (nrst),
		.cfg_we       (cfg_we),
		.cfg_remap    (cfg_remap),
		.cfg_cs_remap (cfg_cs_remap),
		.remap_reg    (remap_reg),
		.cs_remap_reg (cs_remap_reg)
	);

	assign remap_state    = remap_reg;
	assign cs_remap_state = cs_remap_reg;

	// ****************************************
	// decode
	// ****************************************
	wire [5:0] win_cs;
	wire       win_sram;
	wire       win_rsvd;

	pad_smc_window u_win (
		.addr       (req_addr[28:0]),
		.cs_remap   (cs_remap_reg),
		.cs_onehot  (win_cs),
		.secure_ram (win_sram),
		.reserved   (win_rsvd)
	);

	// remap values outside the three documented settings behave like the default
	wire axi_low = (remap_reg == `PAD_RMP_AXI_LOW);
	wire axi_on  = (remap_reg != `PAD_RMP_SMC_AXI_OFF);
	wire low4g   = (req_addr[39:32] == `PAD_LOW4G_TOP);
	// aliases: 0x08_xxxx_xxxx and 0x80_xxxx_xxxx, both 2GB halves
	// bit 31 is free, so one top-byte match covers both 2GB halves
	wire alias_h = (req_addr[39:32] == `PAD_ALIAS_A) ||
		(req_addr[39:32] == `PAD_ALIAS_B);

	reg [`PAD_TGT_W-1:0] tgt_next;
	reg [5:0]            cs_next;

	always @* begin
		tgt_next = `PAD_TGT_NONE;
		cs_next  = 6'h00;
		if (low4g) begin
			if (req_addr < `PAD_SMC_END) begin
				if (axi_low) begin
					tgt_next = `PAD_TGT_EXTAXI;
				end else if (win_sram) begin
					tgt_next = `PAD_TGT_SRAM;
				end else if (!win_rsvd) begin
					tgt_next = `PAD_TGT_SMC;
					cs_next  = win_cs;
				end
			end else if (req_addr < `PAD_PERI1_END) begin
				tgt_next = `PAD_TGT_PERI1;
			end else if (req_addr < `PAD_ACP_END) begin
				tgt_next = `PAD_TGT_ACP;
			end else if (req_addr < `PAD_AXI_END) begin
				if (axi_on)
					tgt_next = `PAD_TGT_EXTAXI;
			end else if (req_addr < `PAD_PERI2_END) begin
				tgt_next = `PAD_TGT_PERI2;
			end else begin
				tgt_next = `PAD_TGT_DDR;
			end
		end else if (alias_h) begin
			tgt_next = `PAD_TGT_DDR;
		end
		// anything else is a reserved gap: left unrouted
	end

	// ****************************************
	// registered result, one cycle after request
	// ****************************************
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dec_valid  <= 1'b0;
			dec_target <= `PAD_TGT_NONE;
			smc_cs     <= 6'h00;
			dec_addr   <= {`PAD_AW{1'b0}};
			ddr_offset <= {`PAD_DDR_OFS_W{1'b0}};
			dec_error  <= 1'b0;
		end else begin
			dec_valid <= req_valid;
			if (req_valid) begin
				dec_target <= tgt_next;
				smc_cs     <= cs_next;
				dec_addr   <= req_addr;
				ddr_offset <= req_addr[`PAD_DDR_OFS_W-1:0];
				dec_error  <= (tgt_next == `PAD_TGT_NONE);
			end else begin
				// no selects held between requests so no target sees a stale strobe
				dec_target <= `PAD_TGT_NONE;
				smc_cs     <= 6'h00;
				dec_error  <= 1'b0;
			end
		end
	end
endmodule

// [pad_addr_decoder_assertions.sv]
// port-level assertions for the physical address decoder
`timescale 1ns/1ps
module pad_dec_chk (
	input wire        clk,
	input wire        nrst,
	input wire        req_valid,
	input wire [39:0] req_addr,
	input wire        cfg_we,
	input wire [1:0]  cfg_remap,
	input wire [1:0]  cfg_cs_remap,
	input wire [1:0]  remap_state,
	input wire [1:0]  cs_remap_state,
	input wire        dec_valid,
	input wire [3:0]  dec_target,
	input wire [5:0]  smc_cs,
	input wire [39:0] dec_addr,
	input wire [30:0] ddr_offset,
	input wire        dec_error
);
	// ****************************************
	// decode timing and map checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	AST_VLD: assert property (req_valid |=> dec_valid && dec_addr == $past(req_addr)) else $error("no answer");
	AST_IDLE: assert property (!req_valid |=> !dec_valid && dec_target == 4'h0) else $error("idle answer");
	AST_ERR: assert property (dec_error == (dec_valid && dec_target == 4'h0)) else $error("bad error flag");
	AST_OFS: assert property (dec_valid |-> ddr_offset == dec_addr[30:0]) else $error("bad offset");
	AST_DDR: assert property (req_valid && req_addr[39:31] == 9'h001 |=> dec_target == 4'h7) else $error("ddr miss");
	AST_ACP: assert property (req_valid && req_addr[39:28] == 12'h003 |=> dec_target == 4'h4) else $error("acp miss");
	AST_CFG: assert property (cfg_we |=> remap_state == $past(cfg_remap)) else $error("remap not loaded");
	AST_CSR: assert property (cfg_we |=> cs_remap_state == $past(cfg_cs_remap)) else $error("cs remap not loaded");
	AST_CS: assert property (dec_target == 4'h1 ? ($onehot(smc_cs) && !smc_cs[5]) : smc_cs == 6'h00) else $error("bad select");
	cover property (req_valid && req_addr[39:35] != 5'h00);
	cover property (cfg_we && cfg_remap == 2'h1);
	cover property (dec_error);
endmodule
bind pad_addr_decoder pad_dec_chk i_pad_dec_chk (.clk(clk), .nrst(nrst), .req_valid(req_valid),
	.req_addr(req_addr), .cfg_we(cfg_we), .cfg_remap(cfg_remap), .cfg_cs_remap(cfg_cs_remap),
	.remap_state(remap_state), .cs_remap_state(cs_remap_state), .dec_valid(dec_valid),
	.dec_target(dec_target), .smc_cs(smc_cs), .dec_addr(dec_addr), .ddr_offset(ddr_offset),
	.dec_error(dec_error));

// [pad_master_model.sv]
// bus master model issuing single accesses to the decoder
`timescale 1ns/1ps
module pad_master_model (
	input  wire        clk,
	output reg         req_valid,
	output reg  [39:0] req_addr
);
	// ****************************************
	// one access per call
	// ****************************************
	initial req_valid = 1'b0;
	initial req_addr = 40'h00_0000_0000;
	// reserved gaps are only hit where the bench asks for it
	task send(input [39:0] a);
		begin
			@(negedge clk);
			req_valid = 1'b1;
			req_addr = a;
			@(negedge clk);
			req_valid = 1'b0;
			// released address shows the inverse so a stale value cannot pass
			req_addr = ~a;
		end
	endtask
endmodule

// [tb.sv]
// self-checking bench for the physical address decoder
`timescale 1ns/1ps
module tb;
	// ****************************************
	// signals, instances, shared tasks
	// ****************************************
	reg         clk = 1'b0;
	reg         nrst = 1'b0;
	reg         cfg_we = 1'b0;
	reg  [1:0]  cfg_remap = 2'h0;
	reg  [1:0]  cfg_cs_remap = 2'h0;
	wire        req_valid;
	wire [39:0] req_addr;
	wire [1:0]  remap_state;
	wire [1:0]  cs_remap_state;
	wire        dec_valid;
	wire        dec_error;
	wire [3:0]  dec_target;
	wire [5:0]  smc_cs;
	wire [39:0] dec_addr;
	wire [30:0] ddr_offset;
	integer     mismatches = 0;
	integer     n_checks = 0;
	always #50 clk = ~clk;
	pad_master_model i_pad_master_model (.clk(clk), .req_valid(req_valid), .req_addr(req_addr));
	pad_addr_decoder i_pad_addr_decoder (.clk(clk), .nrst(nrst), .req_valid(req_valid),
		.req_addr(req_addr), .cfg_we(cfg_we), .cfg_remap(cfg_remap), .cfg_cs_remap(cfg_cs_remap),
		.remap_state(remap_state), .cs_remap_state(cs_remap_state), .dec_valid(dec_valid),
		.dec_target(dec_target), .smc_cs(smc_cs), .dec_addr(dec_addr), .ddr_offset(ddr_offset),
		.dec_error(dec_error));
	task chk(input [8*6:1] nm, input [39:0] s, input [39:0] e);
		begin
			n_checks = n_checks + 1;
			if (s !== e) begin
				mismatches = mismatches + 1;
				$display("unexpected %0s expected %h seen %h", nm, e, s);
			end
		end
	endtask
	task acc(input [39:0] a, input [3:0] t, input [5:0] cs);
		begin
			i_pad_master_model.send(a);
			chk("valid", dec_valid, 40'h1);
			chk("addr", dec_addr, a);
			chk("target", dec_target, t);
			chk("cs", smc_cs, cs);
			chk("error", dec_error, t == 4'h0);
			if (t == 4'h7) chk("offset", ddr_offset, a[30:0]);
		end
	endtask
	task cfg(input [1:0] r, input [1:0] c);
		begin
			@(negedge clk);
			// only the two defined remap fields are ever written
			cfg_we = 1'b1;
			cfg_remap = r;
			cfg_cs_remap = c;
			@(negedge clk);
			cfg_we = 1'b0;
			chk("remap", remap_state, r);
			chk("csmap", cs_remap_state, c);
		end
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task t_map;
		begin
			acc(40'h00_0000_0000, 4'h1, 6'h01);
			acc(40'h00_0800_0000, 4'h1, 6'h01);
			acc(40'h00_0400_0000, 4'h2, 6'h00);
			acc(40'h00_0C00_0000, 4'h1, 6'h10);
			acc(40'h00_1000_0000, 4'h0, 6'h00);
			acc(40'h00_17FF_FFFF, 4'h1, 6'h02);
			acc(40'h00_1800_0000, 4'h1, 6'h04);
			acc(40'h00_1FFF_FFFF, 4'h1, 6'h08);
			acc(40'h00_2000_0000, 4'h3, 6'h00);
			acc(40'h00_3FFF_FFFF, 4'h4, 6'h00);
			acc(40'h00_7FBF_FFFF, 4'h5, 6'h00);
			acc(40'h00_7FC0_0000, 4'h6, 6'h00);
			acc(40'h00_FFFF_FFFF, 4'h7, 6'h00);
			acc(40'h08_0000_0004, 4'h7, 6'h00);
			acc(40'h08_8123_4567, 4'h7, 6'h00);
			acc(40'h80_7FFF_FFFF, 4'h7, 6'h00);
			acc(40'h80_8000_0010, 4'h7, 6'h00);
			acc(40'h01_0000_0000, 4'h0, 6'h00);
			acc(40'h7F_FFFF_FFFF, 4'h0, 6'h00);
			acc(40'h81_0000_0000, 4'h0, 6'h00);
		end
	endtask
	task t_remap;
		begin
			cfg(2'h1, 2'h1);
			acc(40'h00_1FFF_FFFF, 4'h5, 6'h00);
			acc(40'h00_0000_0000, 4'h5, 6'h00);
			cfg(2'h2, 2'h0);
			acc(40'h00_4000_0000, 4'h0, 6'h00);
			acc(40'h00_0000_0000, 4'h1, 6'h01);
			cfg(2'h0, 2'h1);
			acc(40'h00_0000_0000, 4'h1, 6'h10);
			acc(40'h00_4000_0000, 4'h5, 6'h00);
		end
	endtask
	task t_rst;
		begin
			@(negedge clk);
			nrst = 1'b0;
			@(negedge clk);
			chk("remap", remap_state, 40'h0);
			chk("csmap", cs_remap_state, 40'h0);
			nrst = 1'b1;
			acc(40'h00_0000_0000, 4'h1, 6'h01);
		end
	endtask
	task test_done;
		begin
			if (mismatches == 0 && n_checks > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	initial begin
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		t_map;
		t_remap;
		t_rst;
		test_done;
	end
	// far beyond the roughly 64 cycles the scenarios need
	initial begin
		#1000000;
		mismatches = mismatches + 1;
		test_done;
	end
endmodule
